/* hw/event_router_pkg.sv */
// package: register map, selector codes and carriers for the event router
package event_router_pkg;

    // register word indices; each register takes one aligned 32-bit word at four times its index
    localparam logic [7:0] OFS_PIN_OUT_EN   = 8'h00;
    localparam logic [7:0] OFS_SERIAL_ALT   = 8'h01;
    localparam logic [7:0] OFS_TIMER_ALT    = 8'h02;
    localparam logic [7:0] OFS_ASYNC_PULSE  = 8'h03;
    localparam logic [7:0] OFS_SYNC_PULSE   = 8'h04;
    localparam logic [7:0] OFS_ASYNC_CH0    = 8'h05;
    localparam logic [7:0] OFS_ASYNC_CH1    = 8'h06;
    localparam logic [7:0] OFS_SYNC_CH      = 8'h0a;
    localparam logic [7:0] OFS_ASYNC_USER   = 8'h12;
    localparam logic [7:0] OFS_SYNC_USER    = 8'h22;
    localparam int         NUM_ASYNC_USERS  = 11;
    localparam int         NUM_SYNC_USERS   = 2;
    localparam logic [7:0] REG_RESET        = 8'h00;

    // field positions
    localparam int BIT_EVENT_PIN_OUT_ZERO      = 0;
    localparam int BIT_EVENT_PIN_OUT_ONE      = 1;
    localparam int BIT_SERIAL_ALT  = 0;
    localparam int BIT_SPI_ALT     = 2;
    localparam int BIT_WAVE0_ALT   = 0;

    // asynchronous channel generator codes
    localparam logic [7:0] ACH_OFF      = 8'h00;
    localparam logic [7:0] ACH_LUT0     = 8'h01;
    localparam logic [7:0] ACH_LUT1     = 8'h02;
    localparam logic [7:0] ACH_CMP_OUT  = 8'h03;
    localparam logic [7:0] ACH_CLOCK_COUNTER_OVERFLOW  = 8'h08;
    localparam logic [7:0] ACH_CLOCK_COUNTER_COMPARE  = 8'h09;
    localparam logic [7:0] ACH_PIN_LO   = 8'h0a;
    localparam logic [7:0] ACH_PIN_HI   = 8'h11;
    localparam logic [7:0] ACH_DEBUG    = 8'h12;

    // synchronous channel generator codes
    localparam logic [7:0] SCH_TIMER_B  = 8'h01;
    localparam logic [7:0] SCH_TA_LO    = 8'h02;
    localparam logic [7:0] SCH_TA_HI    = 8'h06;
    localparam logic [7:0] SCH_PC_LO    = 8'h07;
    localparam logic [7:0] SCH_PC_HI    = 8'h0c;
    localparam logic [7:0] SCH_PA_LO    = 8'h0d;
    localparam logic [7:0] SCH_PA_HI    = 8'h14;

    // user selector codes
    localparam logic [7:0] USR_OFF      = 8'h00;
    localparam logic [7:0] USR_SYNC0    = 8'h01;
    localparam logic [7:0] USR_ASYNC0   = 8'h03;
    localparam logic [7:0] USR_ASYNC1   = 8'h04;

    // generator inputs arriving from peripherals and pins
    typedef struct packed {
        logic       logic_table_zero_output;
        logic       logic_table_one_output;
        logic       comparator_output;
        logic       clock_counter_overflow;
        logic       clock_counter_compare;
        logic       debug_interface;
        logic [7:0] port_a;
        logic [7:0] port_b;
        logic [5:0] port_c;
        logic       timer_b;
        logic [4:0] timer_a_events;   // low ovf, high unf, compare 0..2
    } gen_in_s;

    // pin placement controls towards the pad ring
    typedef struct packed {
        logic event_pin_out_zero_en;
        logic event_pin_out_one_en;
        logic serial_peripheral_port_alt;
        logic serial_transceiver_alt;
        logic timer_a_wave0_alternate;
    } pin_sel_s;

endpackage : event_router_pkg

/* hw/event_router.sv */
// event routing matrix with pin selection registers behind an apb slave
//
// Operation
// - async channels decode logic, comparator, counter, pins; channel 0 also debug
// - sync channel decodes timer B, timer A, pins
// - sync channel source byte at 0x0a
// - eleven async user selectors from 0x12
// - async users: timer, converter, tables, pins
// - async user codes: off, sync0, async0, async1
// - two sync user selectors from 0x22
// - sync user 0 timer A, 1 transceiver
// - sync user codes: off or sync0
// - bits 0,1 enable event output pins
// - bit 2 moves peripheral port pins
// - bit 0 moves transceiver pins
// - bit 0 moves timer A wave 0
// - split mode applies to low compare 0
// - pulse bit inverts channel one cycle
// - reset leaves everything unconnected
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module event_router
    import event_router_pkg::*;
(
    input  wire logic        core_clk,                     // peripheral clock, 10 MHz
    input  wire logic        reset,                        // async, active high
    input  wire logic        psel,                         // apb select
    input  wire logic        penable,                      // apb access phase
    input  wire logic        pwrite,                       // apb direction
    input  wire logic [7:0]  paddr,                        // apb byte address
    input  wire logic [31:0] pwdata,                       // apb write data
    output logic      [31:0] prdata,                       // apb read data
    output logic             pready,                       // apb ready
    output logic             pslverr,                      // apb error, unmapped
    input  wire gen_in_s     gen_in,                       // event generators
    output logic      [10:0] async_user_event,             // per async user
    output logic      [1:0]  sync_user_event,              // per sync user
    output pin_sel_s         pin_sel                       // pad placement
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] pin_en_q, serial_alt_q, timer_alt_q;
    logic [7:0] async_src_q [2];
    logic [7:0] sync_src_q;
    logic [7:0] async_user_q [NUM_ASYNC_USERS];
    logic [7:0] sync_user_q [NUM_SYNC_USERS];
    logic [1:0] async_pulse_q;
    logic       sync_pulse_q;
    logic       wr_en;
    logic [5:0] widx;

    assign wr_en = psel && penable && pwrite;
    assign widx  = paddr[7:2];

    // software writes; one-cycle apb, every access completes in the access phase
    // reset unconnected
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_en_q     <= REG_RESET;
            serial_alt_q <= REG_RESET;
            timer_alt_q  <= REG_RESET;
            sync_src_q   <= REG_RESET;
            async_src_q  <= '{default: REG_RESET};
            async_user_q <= '{default: REG_RESET};
            sync_user_q  <= '{default: REG_RESET};
        end else if (wr_en) begin
            if (widx == OFS_PIN_OUT_EN[5:0]) pin_en_q <= pwdata[7:0];
            if (widx == OFS_SERIAL_ALT[5:0]) serial_alt_q <= pwdata[7:0];
            if (widx == OFS_TIMER_ALT[5:0]) timer_alt_q <= pwdata[7:0];
            if (widx == OFS_ASYNC_CH0[5:0]) async_src_q[0] <= pwdata[7:0];
            if (widx == OFS_ASYNC_CH1[5:0]) async_src_q[1] <= pwdata[7:0];
            if (widx == OFS_SYNC_CH[5:0]) sync_src_q <= pwdata[7:0];
            for (int i = 0; i < NUM_ASYNC_USERS; i++) begin
                if (widx == 6'(OFS_ASYNC_USER + 8'(i))) async_user_q[i] <= pwdata[7:0];
            end
            for (int i = 0; i < NUM_SYNC_USERS; i++) begin
                if (widx == 6'(OFS_SYNC_USER + 8'(i))) sync_user_q[i] <= pwdata[7:0];
            end
        end
    end

    // strobe writes: one-cycle inversion pulses, self clearing
    // one cycle invert
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            async_pulse_q <= 2'h0;
            sync_pulse_q  <= 1'b0;
        end else begin
            async_pulse_q <= (wr_en && widx == OFS_ASYNC_PULSE[5:0]) ? pwdata[1:0] : 2'h0;
            sync_pulse_q  <= wr_en && widx == OFS_SYNC_PULSE[5:0] && pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    logic [7:0] rd_byte;
    logic       rd_hit;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (widx == OFS_PIN_OUT_EN[5:0])       rd_byte = pin_en_q;
        else if (widx == OFS_SERIAL_ALT[5:0])  rd_byte = serial_alt_q;
        else if (widx == OFS_TIMER_ALT[5:0])   rd_byte = timer_alt_q;
        else if (widx == OFS_ASYNC_PULSE[5:0]) rd_byte = 8'h00;
        else if (widx == OFS_SYNC_PULSE[5:0])  rd_byte = 8'h00;
        else if (widx == OFS_ASYNC_CH0[5:0])   rd_byte = async_src_q[0];
        else if (widx == OFS_ASYNC_CH1[5:0])   rd_byte = async_src_q[1];
        else if (widx == OFS_SYNC_CH[5:0])     rd_byte = sync_src_q;
        else if (widx >= OFS_ASYNC_USER[5:0] && widx < 6'(OFS_ASYNC_USER + 8'(NUM_ASYNC_USERS)))
            rd_byte = async_user_q[4'(widx - OFS_ASYNC_USER[5:0])];
        else if (widx >= OFS_SYNC_USER[5:0] && widx < 6'(OFS_SYNC_USER + 8'(NUM_SYNC_USERS)))
            rd_byte = sync_user_q[1'(widx - OFS_SYNC_USER[5:0])];
        else rd_hit = 1'b0;
    end

    // apb answer registered in the setup cycle, so ready rises with penable
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata  <= (psel && !penable && !pwrite) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: three stages, change accepted when stages 2 and 3 agree
    localparam int NGEN = $bits(gen_in_s);
    logic [NGEN-1:0] s1_q, s2_q, s3_q, gen_q;
    gen_in_s         g;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            gen_q <= '0;
        end else begin
            s1_q  <= gen_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            gen_q <= (s2_q & s3_q) | (gen_q & (s2_q | s3_q));
        end
    end
    assign g = gen_in_s'(gen_q);

    ////////////////////////////////////////////////////////////////////////
    // channel decode
    logic [1:0] async_ch;
    logic       sync_ch;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            logic [7:0] s;
            logic [7:0] pins;
            s    = async_src_q[c];
            pins = (c == 0) ? g.port_a : g.port_b;
            async_ch[c] = 1'b0;
            if (s == ACH_LUT0) async_ch[c] = g.logic_table_zero_output;
            else if (s == ACH_LUT1) async_ch[c] = g.logic_table_one_output;
            else if (s == ACH_CMP_OUT) async_ch[c] = g.comparator_output;
            else if (s == ACH_CLOCK_COUNTER_OVERFLOW) async_ch[c] = g.clock_counter_overflow;
            else if (s == ACH_CLOCK_COUNTER_COMPARE) async_ch[c] = g.clock_counter_compare;
            else if (s >= ACH_PIN_LO && s <= ACH_PIN_HI) async_ch[c] = pins[3'(s - ACH_PIN_LO)];
            else if (c == 0 && s == ACH_DEBUG) async_ch[c] = g.debug_interface;
            async_ch[c] = async_ch[c] ^ async_pulse_q[c];
        end
    end

    always_comb begin
        sync_ch = 1'b0;
        if (sync_src_q == SCH_TIMER_B) sync_ch = g.timer_b;
        else if (sync_src_q >= SCH_TA_LO && sync_src_q <= SCH_TA_HI)
            sync_ch = g.timer_a_events[3'(sync_src_q - SCH_TA_LO)];
        else if (sync_src_q >= SCH_PC_LO && sync_src_q <= SCH_PC_HI)
            sync_ch = g.port_c[3'(sync_src_q - SCH_PC_LO)];
        else if (sync_src_q >= SCH_PA_LO && sync_src_q <= SCH_PA_HI)
            sync_ch = g.port_a[3'(sync_src_q - SCH_PA_LO)];
        sync_ch = sync_ch ^ sync_pulse_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // user multiplexers, registered outputs
    // async user map
    genvar u;
    generate
        for (u = 0; u < NUM_ASYNC_USERS; u++) begin : g_async_user
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    async_user_event[u] <= 1'b0;
                end else begin
                    unique case (async_user_q[u])
                        USR_SYNC0:  async_user_event[u] <= sync_ch;
                        USR_ASYNC0: async_user_event[u] <= async_ch[0];
                        USR_ASYNC1: async_user_event[u] <= async_ch[1];
                        default:    async_user_event[u] <= 1'b0;   // off and reserved
                    endcase
                end
            end
        end
        for (u = 0; u < NUM_SYNC_USERS; u++) begin : g_sync_user
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) sync_user_event[u] <= 1'b0;
                else sync_user_event[u] <= (sync_user_q[u] == USR_SYNC0) && sync_ch;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin placement controls; the timer's split-mode low compare 0 shares
    // the same pad steering, so one bit covers both modes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_sel <= '0;
        end else begin
            pin_sel.event_pin_out_zero_en      <= pin_en_q[BIT_EVENT_PIN_OUT_ZERO];
            pin_sel.event_pin_out_one_en       <= pin_en_q[BIT_EVENT_PIN_OUT_ONE];
            pin_sel.serial_peripheral_port_alt <= serial_alt_q[BIT_SPI_ALT];
            pin_sel.serial_transceiver_alt     <= serial_alt_q[BIT_SERIAL_ALT];
            pin_sel.timer_a_wave0_alternate    <= timer_alt_q[BIT_WAVE0_ALT];
        end
    end

endmodule : event_router

/* test/event_router_monitor.sv */
// checker: bus timing and pin-select outputs of the event router
`timescale 1ns/1ns
module event_router_monitor
    import event_router_pkg::*;
(
    input wire logic        core_clk,          // clock
    input wire logic        reset,             // async reset
    input wire logic        psel,              // apb select
    input wire logic        penable,           // apb access
    input wire logic        pwrite,            // apb direction
    input wire logic [7:0]  paddr,             // apb address
    input wire logic [31:0] pwdata,            // apb write data
    input wire logic [31:0] prdata,            // apb read data
    input wire logic        pready,            // apb ready
    input wire logic        pslverr,           // apb error
    input wire logic [10:0] async_user_event,  // async users
    input wire logic [1:0]  sync_user_event,   // sync users
    input wire pin_sel_s    pin_sel            // pad placement
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_ready_first: assert property (psel && penable && !$past(penable) |-> pready)
        else $error("ready missing in first access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_err_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside an access");
    a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data above the byte");
    a_reset_clear: assert property ($fell(reset) |-> pin_sel == '0
        && async_user_event == '0 && sync_user_event == '0)
        else $error("outputs not clear after reset");
    // write lands at the ready edge, the pad copy follows one flop later
    a_evout_en: assert property (pready && pwrite && paddr == 8'h00 |-> ##2
        pin_sel.event_pin_out_zero_en == $past(pwdata[0], 2)
        && pin_sel.event_pin_out_one_en == $past(pwdata[1], 2))
        else $error("event pin enables do not follow write");
    a_serial_alt: assert property (pready && pwrite && paddr == 8'h04 |-> ##2
        pin_sel.serial_peripheral_port_alt == $past(pwdata[2], 2)
        && pin_sel.serial_transceiver_alt == $past(pwdata[0], 2))
        else $error("serial alternates do not follow write");
    a_wave_alt: assert property (pready && pwrite && paddr == 8'h08 |-> ##2
        pin_sel.timer_a_wave0_alternate == $past(pwdata[0], 2))
        else $error("wave0 alternate does not follow write");
endmodule : event_router_monitor
bind event_router event_router_monitor mon (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_sel(pin_sel),
    .async_user_event(async_user_event), .sync_user_event(sync_user_event));

/* test/event_gen_model.sv */
// partner: peripherals and pins that raise event levels
`timescale 1ns/1ns
module event_gen_model
    import event_router_pkg::*;
(
    input wire logic    core_clk,  // register clock
    input wire gen_in_s want,      // levels the bench asks for
    output gen_in_s     gen_in     // levels towards the router
);
    // generators are unrelated to the register clock, so move off its rising edge
    always @(negedge core_clk) begin
        gen_in <= want;
    end
endmodule : event_gen_model

/* test/event_router_tb_top.sv */
// testbench: registers, routing, strobes and pin select of the event router
`timescale 1ns/1ns
module event_router_tb_top
    import event_router_pkg::*;
;
    logic        core_clk = 1'b0;  // bench clock
    logic        reset    = 1'b1;  // held at start
    logic        psel     = 1'b0;  // apb master signals
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    gen_in_s     want     = '0;
    gen_in_s     gen_in;
    logic [10:0] async_user_event;
    logic [1:0]  sync_user_event;
    pin_sel_s    pin_sel;
    wire  [12:0] all_ev   = {sync_user_event, async_user_event};
    int          mismatches = 0;
    int          compares   = 0;
    always #50 core_clk = ~core_clk;
    event_router dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_in(gen_in), .async_user_event(async_user_event),
        .sync_user_event(sync_user_event), .pin_sel(pin_sel));
    event_gen_model gm (.core_clk(core_clk), .want(want), .gen_in(gen_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // one apb transfer; byte address is four times the register index
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i[5:0], 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, i, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, i, 32'h0, r, e);
        chk("read data", r, {24'h0, x});
        chk("read error", 32'(e), 32'h0);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    // level on the generator that a channel code names
    function automatic gen_in_s gen_for(input bit sy, input bit ch, input logic [7:0] c);
        gen_in_s g;
        g = '0;
        if (sy) begin
            if (c == 8'h01) g.timer_b = 1'b1;
            else if (c <= 8'h06) g.timer_a_events[3'(c - 8'h02)] = 1'b1;
            else if (c <= 8'h0c) g.port_c[3'(c - 8'h07)] = 1'b1;
            else g.port_a[3'(c - 8'h0d)] = 1'b1;
        end else begin
            case (c)
                8'h01: g.logic_table_zero_output = 1'b1;
                8'h02: g.logic_table_one_output = 1'b1;
                8'h03: g.comparator_output = 1'b1;
                8'h08: g.clock_counter_overflow = 1'b1;
                8'h09: g.clock_counter_compare = 1'b1;
                8'h12: g.debug_interface = 1'b1;
                default: if (ch) g.port_b[3'(c - 8'h0a)] = 1'b1; else g.port_a[3'(c - 8'h0a)] = 1'b1;
            endcase
        end
        return g;
    endfunction : gen_for
    // program one channel and one user, raise the generator, then drop it
    task automatic route(input bit sy, input bit ch, input logic [7:0] c, input int u,
                         input logic [7:0] uc, input logic ex);
        logic [7:0] sa;
        sa = sy ? OFS_SYNC_CH : (ch ? OFS_ASYNC_CH1 : OFS_ASYNC_CH0);
        wr(sa, {24'h0, c});
        rd(sa, c);
        wr(u < 11 ? OFS_ASYNC_USER + 8'(u) : OFS_SYNC_USER + 8'(u - 11), {24'h0, uc});
        want <= gen_for(sy, ch, c);
        repeat (7) @(posedge core_clk);
        chk("user event on", 32'(all_ev[u]), 32'(ex));
        want <= '0;
        repeat (7) @(posedge core_clk);
        chk("user event off", 32'(all_ev[u]), 32'h0);
    endtask : route
    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_regs;
        logic [31:0] r;
        logic        e;
        chk("pin_sel reset", 32'(pin_sel), 32'h0);
        // indices 0 to 6 are mapped, then the sync channel source at 0x0a
        for (int k = 0; k < 8; k++) rd(k < 7 ? 8'(k) : OFS_SYNC_CH, 8'h00);
        for (int k = 0; k < 13; k++) rd(k < 11 ? 8'h12 + 8'(k) : 8'h17 + 8'(k), 8'h00);
        wr(OFS_ASYNC_USER + 8'd10, 32'hffffff5a);
        rd(OFS_ASYNC_USER + 8'd10, 8'h5a);
        apb(1'b0, 8'h3f, 32'h0, r, e);
        chk("unmapped data", r, 32'h0);
        chk("unmapped error", 32'(e), 32'h1);
    endtask : sc_regs
    task automatic sc_pins;
        wr(OFS_PIN_OUT_EN, 32'h03);
        wr(OFS_SERIAL_ALT, 32'h05);
        wr(OFS_TIMER_ALT, 32'h01);
        // pad copies trail the register by one flop, so let two edges pass
        repeat (2) @(posedge core_clk);
        chk("pins all set", 32'(pin_sel), 32'h1f);
        wr(OFS_PIN_OUT_EN, 32'h02);
        wr(OFS_SERIAL_ALT, 32'h04);
        wr(OFS_TIMER_ALT, 32'h00);
        repeat (2) @(posedge core_clk);
        chk("pins mixed", 32'(pin_sel), 32'h0c);
        rd(OFS_SERIAL_ALT, 8'h04);
    endtask : sc_pins
    task automatic sc_routes;
        for (int c = 1; c <= 18; c++) if (c < 4 || c > 7) route(0, 0, 8'(c), c % 2 ? c % 6 : 8 + c % 3, USR_ASYNC0, 1);
        for (int c = 1; c <= 17; c++) if (c < 4 || c > 7) route(0, 1, 8'(c), 8 + c % 3, USR_ASYNC1, 1);
        for (int c = 1; c <= 20; c++) route(1, 0, 8'(c), 11 + c % 2, USR_SYNC0, 1);
        route(1, 0, 8'h01, 1, USR_SYNC0, 1);
        route(0, 0, 8'h04, 0, USR_ASYNC0, 0);
        route(0, 1, 8'h12, 9, USR_ASYNC1, 0);
        route(1, 0, 8'h15, 12, USR_SYNC0, 0);
        route(0, 0, 8'h01, 2, 8'h02, 0);
        route(1, 0, 8'h01, 11, 8'h03, 0);
    endtask : sc_routes
    // strobe must invert an idle channel for exactly one cycle
    task automatic sc_strobe(input logic [7:0] pr, input logic [7:0] so, input int u,
                             input logic [7:0] uc);
        int hi;
        wr(so, 32'h0);
        wr(u < 11 ? OFS_ASYNC_USER + 8'(u) : OFS_SYNC_USER + 8'(u - 11), {24'h0, uc});
        wr(pr, 32'h1);
        hi = 0;
        repeat (12) begin
            @(posedge core_clk);
            if (all_ev[u] === 1'b1) hi++;
        end
        chk("strobe cycles", 32'(hi), 32'h1);
    endtask : sc_strobe
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        sc_regs();
        sc_pins();
        sc_routes();
        sc_strobe(OFS_ASYNC_PULSE, OFS_ASYNC_CH0, 0, USR_ASYNC0);
        sc_strobe(OFS_SYNC_PULSE, OFS_SYNC_CH, 11, USR_SYNC0);
        test_done();
    end
endmodule : event_router_tb_top
